// ==== rtl/cbl_boot_regs.svh ====
// cbl_boot_regs.svh: offsets, field positions, reset values of the
// boot loader and bus window; included by bare name, definitions only
`ifndef CBL_BOOT_REGS_SVH
`define CBL_BOOT_REGS_SVH

// ==========================================================
// host-side register index (host_req.addr)
`define CBL_H_MAP      3'h0
`define CBL_H_CTRL     3'h1
`define CBL_H_DEST     3'h2
`define CBL_H_SRC      3'h3
`define CBL_H_CORE     3'h4

// ==========================================================
// core-side special-function register addresses
`define CBL_CORE_MEMORY_MAP   8'hf2
`define CBL_SFR_AD0RD  8'hf6
`define CBL_SFR_AD0WR  8'hf7
`define CBL_SFR_AD1    8'hf9
`define CBL_SFR_DA0    8'hfc

// ==========================================================
// field positions
`define CBL_CTRL_GO    0
`define CBL_CTRL_RB    1
`define CBL_CORE_REL   0
`define CBL_CORE_PROT  1
`define CBL_CORE_AUTO  2
`define CBL_CORE_RUN   3
`define CBL_CORE_BUSY  4
`define CBL_MM_DL      0
`define CBL_MM_DH      1
`define CBL_MM_CL      2
`define CBL_MM_CH      3
`define CBL_MM_SDL     4
`define CBL_MM_SDH     5
`define CBL_MM_SCL     6
`define CBL_MM_SCH     7

// ==========================================================
// reset values
`define CBL_MAP_RST    8'h00
`define CBL_SRC_RST    32'h0000_0000
`define CBL_DEST_RST   32'h0000_0000
`define CBL_WORD_RST   32'h0000_0000
`define CBL_STRAP_FILL 2'h3

`endif

// ==== rtl/cbl_boot_pkg.sv ====
// cbl_boot_pkg: types shared by the boot loader and bus window
// assumes nothing beyond a SystemVerilog compiler
package cbl_boot_pkg;

  typedef logic [31:0] cbl_word_t;

  // ==========================================================
  // request and answer carriers
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    cbl_word_t  wdata;
  } cbl_host_req_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cbl_sfr_req_s;

  typedef struct packed {
    logic        en;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cbl_mem_req_s;

  typedef struct packed {
    logic      req;
    logic      we;
    cbl_word_t addr;
    cbl_word_t wdata;
  } cbl_sb_req_s;

  typedef struct packed {
    logic      ack;
    cbl_word_t rdata;
  } cbl_sb_rsp_s;

  typedef struct packed {
    logic        hit;
    logic [15:0] addr;
  } cbl_map_s;

  // ==========================================================
  // state machines
  typedef enum logic [1:0] {LD_IDLE, LD_ISSUE, LD_WAIT} cbl_ld_e;
  typedef enum logic {AC_IDLE, AC_WAIT} cbl_ac_e;

endpackage : cbl_boot_pkg

// ==== rtl/cbl_boot_window.sv ====
// cbl_boot_window: start-up loader, memory map and shared-bus window
// for an embedded core; assumes host and core ports and the shared
// bus all run on sys_clk, and that the core halts while clk_en is low
//
// Overview of operation
// - straps pick auto run or hold until host release
// - go starts copy; clears after the last word
// - equal first and last addresses move one word
// - internal counters advance; programmed values stay put
// - core clock gated while a copy runs
// - readback set copies memory to bus, else bus to memory
// - memory hidden by default; map is host map OR core map
// - host map may survive core soft reset
// - code goes to bus unless its region bit maps it
// - data goes to bus unless its region bit maps it
// - region half select picks lower or upper memory half
// - map 0x15: code in lower half, data at n plus 0x8000
// - core clock gated during window bus accesses
// - window moves full words; address bits 1:0 are zero
// - four byte registers hold address, four hold data
// - read-trigger write starts read, fills data bytes
// - write-trigger write launches the bus write
// - hardware alters only data bytes, only on reads
`timescale 1ns/10ps
`include "cbl_boot_regs.svh"

module cbl_boot_window #(
  parameter int                 MEM_WORDS  = 16384,
  parameter int                 STRAP_W    = 2,
  parameter logic [STRAP_W-1:0] STRAP_AUTO = 2'h1
) (
  // clock and resets
  input  wire logic                       sys_clk,
  input  wire logic                       nrst,
  input  wire logic                       core_soft_rst,
  // strapping pins
  input  wire logic [STRAP_W-1:0]         boot_strap_pins,
  // host register port
  input  wire cbl_boot_pkg::cbl_host_req_s host_req,
  output logic [31:0]                     host_rdata,
  // core special-function register port
  input  wire cbl_boot_pkg::cbl_sfr_req_s  sfr_req,
  output logic [7:0]                      sfr_rdata,
  // core run control
  output logic                            core_rst_n,
  output logic                            core_clk_en,
  // core code and data memory ports
  input  wire cbl_boot_pkg::cbl_mem_req_s  code_req,
  input  wire cbl_boot_pkg::cbl_mem_req_s  data_req,
  output logic                            code_to_mem,
  output logic                            data_to_mem,
  output logic [7:0]                      code_rdata,
  output logic [7:0]                      data_rdata,
  // shared system bus master
  output cbl_boot_pkg::cbl_sb_req_s        sb_req,
  input  wire cbl_boot_pkg::cbl_sb_rsp_s   sb_rsp
);
  import cbl_boot_pkg::*;

  localparam int AW = $clog2(MEM_WORDS);

  // ==========================================================
  // declarations
  logic [STRAP_W-1:0] strap_s1_q, strap_s2_q, strap_s3_q;
  logic [1:0]         fill_q;
  logic               strap_done_q, auto_boot_q;
  logic               release_q, protect_q, run_q;
  logic [7:0]         host_map_q, core_map_q, eff_map;
  logic               go_q, readback_q;
  cbl_word_t          dest_q, src_q, addr_q, data_q;
  cbl_ld_e            ld_st_q;
  cbl_ac_e            ac_st_q;
  cbl_sb_req_s        sb_q;
  cbl_word_t          ld_src_q;
  logic [AW-1:0]      ld_idx_q, ld_last_q;
  logic               ld_fin, ld_wr, ac_rd_done;
  logic               sfr_wr_ok, rd_go, wr_go;
  cbl_word_t          win_addr;
  cbl_map_s           code_hit, data_hit;
  logic [31:0]        host_rdata_q;
  logic [7:0]         sfr_rdata_q, code_rdata_q, data_rdata_q;
  logic [31:0]        mem_q [MEM_WORDS];

  // ==========================================================
  // map decode, shared by code and data paths
  function automatic cbl_map_s map_addr(input logic [7:0]  mm,
                                        input logic        is_code,
                                        input logic [15:0] a);
    cbl_map_s r;
    logic     en;
    logic     sel;
    if (is_code) begin
      en  = a[15] ? mm[`CBL_MM_CH]  : mm[`CBL_MM_CL];
      sel = a[15] ? mm[`CBL_MM_SCH] : mm[`CBL_MM_SCL];
    end else begin
      en  = a[15] ? mm[`CBL_MM_DH]  : mm[`CBL_MM_DL];
      sel = a[15] ? mm[`CBL_MM_SDH] : mm[`CBL_MM_SDL];
    end
    r.hit  = en;
    r.addr = {sel, a[14:0]};
    return r;
  endfunction : map_addr

  // ==========================================================
  // strap capture: three stages, taken once two stages agree
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      strap_s1_q <= '0;
      strap_s2_q <= '0;
      strap_s3_q <= '0;
    end else begin
      strap_s1_q <= boot_strap_pins;
      strap_s2_q <= strap_s1_q;
      strap_s3_q <= strap_s2_q;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fill_q       <= 2'h0;
      strap_done_q <= 1'b0;
      auto_boot_q  <= 1'b0;
    end else if (!strap_done_q) begin
      if (fill_q != `CBL_STRAP_FILL) begin
        fill_q <= fill_q + 2'h1;
      end else if (strap_s2_q == strap_s3_q) begin
        strap_done_q <= 1'b1;
        auto_boot_q  <= (strap_s3_q == STRAP_AUTO);
      end
    end
  end

  // core runs on auto boot, or once the host releases it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      run_q <= 1'b0;
    end else begin
      run_q <= strap_done_q & (auto_boot_q | release_q)
               & ~core_soft_rst;
    end
  end

  // ==========================================================
  // host-side registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      release_q <= 1'b0;
      protect_q <= 1'b0;
      dest_q    <= `CBL_DEST_RST;
      src_q     <= `CBL_SRC_RST;
    end else if (host_req.wr) begin
      unique case (host_req.addr)
        `CBL_H_CORE: begin
          release_q <= host_req.wdata[`CBL_CORE_REL];
          protect_q <= host_req.wdata[`CBL_CORE_PROT];
        end
        `CBL_H_DEST: dest_q <= host_req.wdata;
        `CBL_H_SRC:  src_q  <= host_req.wdata;
        default: ;
      endcase
    end
  end

  // host map survives soft reset only while protected
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      host_map_q <= `CBL_MAP_RST;
    end else if (core_soft_rst && !protect_q) begin
      host_map_q <= `CBL_MAP_RST;
    end else if (host_req.wr && host_req.addr == `CBL_H_MAP) begin
      host_map_q <= host_req.wdata[7:0];
    end
  end

  // control is frozen while go stands, so a copy cannot be restarted
  // or have its direction flipped midway
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      go_q       <= 1'b0;
      readback_q <= 1'b0;
    end else if (go_q) begin
      if (ld_fin) begin
        go_q <= 1'b0;
      end
    end else if (host_req.wr && host_req.addr == `CBL_H_CTRL) begin
      go_q       <= host_req.wdata[`CBL_CTRL_GO];
      readback_q <= host_req.wdata[`CBL_CTRL_RB];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      host_rdata_q <= `CBL_WORD_RST;
    end else if (host_req.rd) begin
      host_rdata_q <= `CBL_WORD_RST;
      unique case (host_req.addr)
        `CBL_H_MAP:  host_rdata_q[7:0] <= host_map_q;
        `CBL_H_CTRL: host_rdata_q[1:0] <= {readback_q, go_q};
        `CBL_H_DEST: host_rdata_q <= dest_q;
        `CBL_H_SRC:  host_rdata_q <= src_q;
        `CBL_H_CORE: host_rdata_q[4:0] <= {go_q, run_q, auto_boot_q,
                                           protect_q, release_q};
        default: ;
      endcase
    end
  end

  // ==========================================================
  // core-side registers; the core only writes while clocked
  assign sfr_wr_ok = sfr_req.wr & core_clk_en;
  assign rd_go     = sfr_wr_ok & (sfr_req.addr == `CBL_SFR_AD0RD);
  assign wr_go     = sfr_wr_ok & (sfr_req.addr == `CBL_SFR_AD0WR);
  // new low byte takes effect in the trigger cycle itself
  assign win_addr  = {addr_q[31:8], sfr_req.wdata[7:2], 2'b00};

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      core_map_q <= `CBL_MAP_RST;
    end else if (core_soft_rst) begin
      core_map_q <= `CBL_MAP_RST;
    end else if (sfr_wr_ok && sfr_req.addr == `CBL_CORE_MEMORY_MAP) begin
      core_map_q <= sfr_req.wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      addr_q <= `CBL_WORD_RST;
    end else if (core_soft_rst) begin
      addr_q <= `CBL_WORD_RST;
    end else if (rd_go || wr_go) begin
      addr_q[7:2] <= sfr_req.wdata[7:2];
    end else if (sfr_wr_ok) begin
      for (int i = 1; i < 4; i++) begin
        if (sfr_req.addr == 8'(`CBL_SFR_AD1 + i - 1)) begin
          addr_q[i*8 +: 8] <= sfr_req.wdata;
        end
      end
    end
  end

  // read results win: they land only while the core is gated
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      data_q <= `CBL_WORD_RST;
    end else if (core_soft_rst) begin
      data_q <= `CBL_WORD_RST;
    end else if (ac_rd_done) begin
      data_q <= sb_rsp.rdata;
    end else if (sfr_wr_ok) begin
      for (int i = 0; i < 4; i++) begin
        if (sfr_req.addr == 8'(`CBL_SFR_DA0 + i)) begin
          data_q[i*8 +: 8] <= sfr_req.wdata;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sfr_rdata_q <= 8'h00;
    end else if (sfr_req.rd) begin
      sfr_rdata_q <= 8'h00;
      if (sfr_req.addr == `CBL_CORE_MEMORY_MAP) begin
        sfr_rdata_q <= core_map_q;
      end
      if (sfr_req.addr == `CBL_SFR_AD0RD ||
          sfr_req.addr == `CBL_SFR_AD0WR) begin
        sfr_rdata_q <= {addr_q[7:2], 2'b00};
      end
      for (int i = 0; i < 4; i++) begin
        if (sfr_req.addr == 8'(`CBL_SFR_DA0 + i)) begin
          sfr_rdata_q <= data_q[i*8 +: 8];
        end
        if (i > 0 && sfr_req.addr == 8'(`CBL_SFR_AD1 + i - 1)) begin
          sfr_rdata_q <= addr_q[i*8 +: 8];
        end
      end
    end
  end

  // ==========================================================
  // shared-bus master: loader copy and core window access
  assign ld_fin     = (ld_st_q == LD_WAIT) & sb_rsp.ack
                      & (ld_idx_q == ld_last_q);
  assign ld_wr      = (ld_st_q == LD_WAIT) & sb_rsp.ack & ~readback_q;
  assign ac_rd_done = (ac_st_q == AC_WAIT) & sb_rsp.ack & ~sb_q.we;

  // window triggers need core_clk_en, which is low while go stands,
  // so the two masters never issue in the same cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ld_st_q   <= LD_IDLE;
      ac_st_q   <= AC_IDLE;
      sb_q      <= '0;
      ld_src_q  <= `CBL_WORD_RST;
      ld_idx_q  <= '0;
      ld_last_q <= '0;
    end else begin
      unique case (ld_st_q)
        LD_IDLE: begin
          if (go_q && ac_st_q == AC_IDLE) begin
            // working copies; programmed values stay untouched
            ld_src_q  <= {src_q[31:2], 2'b00};
            ld_idx_q  <= dest_q[AW+1:2];
            ld_last_q <= dest_q[AW+17:18];
            ld_st_q   <= LD_ISSUE;
          end
        end
        LD_ISSUE: begin
          sb_q.req   <= 1'b1;
          sb_q.we    <= readback_q;
          sb_q.addr  <= ld_src_q;
          sb_q.wdata <= mem_q[ld_idx_q];
          ld_st_q    <= LD_WAIT;
        end
        LD_WAIT: begin
          if (sb_rsp.ack) begin
            sb_q.req <= 1'b0;
            if (ld_idx_q == ld_last_q) begin
              ld_st_q <= LD_IDLE;
            end else begin
              ld_idx_q <= ld_idx_q + 1'b1;
              ld_src_q <= ld_src_q + 32'h4;
              ld_st_q  <= LD_ISSUE;
            end
          end
        end
        default: ld_st_q <= LD_IDLE;
      endcase
      unique case (ac_st_q)
        AC_IDLE: begin
          if (rd_go || wr_go) begin
            sb_q.req   <= 1'b1;
            sb_q.we    <= wr_go;
            sb_q.addr  <= win_addr;
            sb_q.wdata <= data_q;
            ac_st_q    <= AC_WAIT;
          end
        end
        AC_WAIT: begin
          if (sb_rsp.ack) begin
            sb_q.req <= 1'b0;
            ac_st_q  <= AC_IDLE;
          end
        end
      endcase
    end
  end

  assign sb_req = sb_q;

  // core halts during copies and window accesses
  assign core_clk_en = run_q & ~go_q
                       & (ac_st_q == AC_IDLE);
  assign core_rst_n  = run_q;

  // ==========================================================
  // on-chip memory and core map
  assign eff_map  = host_map_q | core_map_q;
  assign code_hit = map_addr(eff_map, 1'b1, code_req.addr);
  assign data_hit = map_addr(eff_map, 1'b0, data_req.addr);
  // unmapped accesses are left to the core's shared-bus path
  assign code_to_mem = code_hit.hit;
  assign data_to_mem = data_hit.hit;

  always_ff @(posedge sys_clk) begin
    if (ld_wr) begin
      mem_q[ld_idx_q] <= sb_rsp.rdata;
    end else if (core_clk_en && data_req.en && data_req.we
                 && data_hit.hit) begin
      mem_q[data_hit.addr[AW+1:2]][{data_hit.addr[1:0], 3'b000} +: 8]
        <= data_req.wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      code_rdata_q <= 8'h00;
      data_rdata_q <= 8'h00;
    end else begin
      if (code_req.en && code_hit.hit) begin
        code_rdata_q <= mem_q[code_hit.addr[AW+1:2]]
                        [{code_hit.addr[1:0], 3'b000} +: 8];
      end
      if (data_req.en && !data_req.we && data_hit.hit) begin
        data_rdata_q <= mem_q[data_hit.addr[AW+1:2]]
                        [{data_hit.addr[1:0], 3'b000} +: 8];
      end
    end
  end

  assign host_rdata = host_rdata_q;
  assign sfr_rdata  = sfr_rdata_q;
  assign code_rdata = code_rdata_q;
  assign data_rdata = data_rdata_q;

endmodule : cbl_boot_window

// ==== tb/cbl_boot_window_asserts.sv ====
// checker for the boot loader and bus window, bound to its top ports
// assumes a single sys_clk domain with nrst active low
`timescale 1ns/10ps
`include "cbl_boot_regs.svh"
module cbl_boot_window_asserts (
  // clock and resets
  input wire logic                          sys_clk,
  input wire logic                          nrst,
  input wire logic                          core_soft_rst,
  // register ports
  input wire cbl_boot_pkg::cbl_host_req_s   host_req,
  input wire cbl_boot_pkg::cbl_sfr_req_s    sfr_req,
  // core side
  input wire logic                          core_rst_n,
  input wire logic                          core_clk_en,
  input wire cbl_boot_pkg::cbl_mem_req_s    code_req,
  input wire cbl_boot_pkg::cbl_mem_req_s    data_req,
  input wire logic                          code_to_mem,
  input wire logic                          data_to_mem,
  // shared bus
  input wire cbl_boot_pkg::cbl_sb_req_s     sb_req,
  input wire cbl_boot_pkg::cbl_sb_rsp_s     sb_rsp
);
  import cbl_boot_pkg::*;
  logic [7:0] hmap_q;
  logic [7:0] cmap_q;
  logic       prot_q;
  logic [7:0] mm;
  // ==========================================================
  // mirrors of the two map registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hmap_q <= `CBL_MAP_RST;
    end else if (core_soft_rst && !prot_q) begin
      hmap_q <= `CBL_MAP_RST;
    end else if (host_req.wr && host_req.addr == `CBL_H_MAP) begin
      hmap_q <= host_req.wdata[7:0];
    end
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prot_q <= 1'b0;
    end else if (host_req.wr && host_req.addr == `CBL_H_CORE) begin
      prot_q <= host_req.wdata[`CBL_CORE_PROT];
    end
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cmap_q <= `CBL_MAP_RST;
    end else if (core_soft_rst) begin
      cmap_q <= `CBL_MAP_RST;
    end else if (sfr_req.wr && core_clk_en &&
                 sfr_req.addr == `CBL_CORE_MEMORY_MAP) begin
      cmap_q <= sfr_req.wdata;
    end
  end
  assign mm = hmap_q | cmap_q;
  // ==========================================================
  // properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_rd_go;
    sfr_req.wr && core_clk_en && sfr_req.addr == `CBL_SFR_AD0RD;
  endsequence
  sequence s_wr_go;
    sfr_req.wr && core_clk_en && sfr_req.addr == `CBL_SFR_AD0WR;
  endsequence
  sequence s_release;
    host_req.wr && host_req.addr == `CBL_H_CORE &&
    host_req.wdata[`CBL_CORE_REL] && !core_soft_rst;
  endsequence
  a_bus_gates_core: assert property (
    sb_req.req |-> !core_clk_en) else $error("core runs during bus use");
  a_word_aligned: assert property (
    sb_req.req |-> sb_req.addr[1:0] == 2'h0) else $error("unaligned");
  a_read_launch: assert property (
    s_rd_go |=> sb_req.req && !sb_req.we) else $error("no read issued");
  a_write_launch: assert property (
    s_wr_go |=> sb_req.req && sb_req.we) else $error("no write issued");
  a_req_held: assert property (
    sb_req.req && !sb_rsp.ack |=> sb_req.req && $stable(sb_req.addr))
    else $error("request dropped before ack");
  a_req_released: assert property (
    sb_req.req && sb_rsp.ack |=> !sb_req.req) else $error("req after ack");
  a_code_map: assert property (
    code_req.en && core_clk_en |-> code_to_mem ==
    (code_req.addr[15] ? mm[`CBL_MM_CH] : mm[`CBL_MM_CL]))
    else $error("code mapping wrong");
  a_data_map: assert property (
    data_req.en && core_clk_en |-> data_to_mem ==
    (data_req.addr[15] ? mm[`CBL_MM_DH] : mm[`CBL_MM_DL]))
    else $error("data mapping wrong");
  a_release_runs: assert property (
    s_release |-> ##[1:8] core_rst_n) else $error("core not released");
endmodule : cbl_boot_window_asserts

bind cbl_boot_window cbl_boot_window_asserts u_chk (
  .sys_clk(sys_clk), .nrst(nrst), .core_soft_rst(core_soft_rst),
  .host_req(host_req), .sfr_req(sfr_req), .core_rst_n(core_rst_n),
  .core_clk_en(core_clk_en), .code_req(code_req), .data_req(data_req),
  .code_to_mem(code_to_mem), .data_to_mem(data_to_mem),
  .sb_req(sb_req), .sb_rsp(sb_rsp)
);

// ==== tb/cbl_sb_slave.sv ====
// shared-bus slave model: 16 words, settable ack latency
// assumes the master holds each request until it sees ack
`timescale 1ns/10ps
module cbl_sb_slave (
  // clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      nrst,
  // shared bus
  input  wire cbl_boot_pkg::cbl_sb_req_s sb_req,
  output cbl_boot_pkg::cbl_sb_rsp_s      sb_rsp,
  // control and observation
  input  wire logic [3:0]                lat,
  output logic [15:0]                    rd_count,
  output cbl_boot_pkg::cbl_word_t        wr_addr,
  output cbl_boot_pkg::cbl_word_t        wr_data
);
  import cbl_boot_pkg::*;
  cbl_word_t  mem [16];
  logic [3:0] cnt;
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 16; i++)
        mem[i] <= {4{8'h10 + 8'(i)}};
      sb_rsp   <= '0;
      cnt      <= 4'h0;
      rd_count <= 16'h0;
      wr_addr  <= '0;
      wr_data  <= '0;
    end else begin
      sb_rsp.ack   <= 1'b0;
      // released data lines toggle so a stale word never looks valid
      sb_rsp.rdata <= ~sb_rsp.rdata;
      if (sb_req.req && !sb_rsp.ack) begin
        cnt <= cnt + 4'h1;
        if (cnt >= lat) begin
          cnt        <= 4'h0;
          sb_rsp.ack <= 1'b1;
          if (sb_req.we) begin
            mem[sb_req.addr[5:2]] <= sb_req.wdata;
            wr_addr               <= sb_req.addr;
            wr_data               <= sb_req.wdata;
          end else begin
            sb_rsp.rdata <= mem[sb_req.addr[5:2]];
            rd_count     <= rd_count + 16'h1;
          end
        end
      end
    end
  end
endmodule : cbl_sb_slave

// ==== tb/tb_cbl_boot_window.sv ====
// self-checking bench for the boot loader and bus window
// assumes slave model and checker are compiled before it
`timescale 1ns/10ps
`include "cbl_boot_regs.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  errors++; $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module tb_cbl_boot_window;
  import cbl_boot_pkg::*;
  typedef struct packed {
    logic [7:0] map; logic [15:0] a; logic c; logic d;
  } cbl_tb_row_s;
  localparam cbl_tb_row_s ROWS [8] = '{
    '{8'h00, 16'h0010, 1'b0, 1'b0}, '{8'haf, 16'h9000, 1'b1, 1'b1},
    '{8'h15, 16'h0100, 1'b1, 1'b1}, '{8'h15, 16'h8100, 1'b0, 1'b0},
    '{8'h04, 16'h0200, 1'b1, 1'b0}, '{8'h08, 16'h8000, 1'b1, 1'b0},
    '{8'h01, 16'h7ffc, 1'b0, 1'b1}, '{8'h02, 16'hc000, 1'b0, 1'b1}};
  logic          sys_clk, nrst, core_soft_rst, core_rst_n, core_clk_en;
  logic          code_to_mem, data_to_mem;
  logic [1:0]    straps;
  logic [3:0]    lat;
  logic [7:0]    sfr_rdata, code_rdata, data_rdata, b;
  logic [15:0]   rd_count;
  cbl_word_t     host_rdata, wr_addr, wr_data, rv;
  cbl_host_req_s host_req;
  cbl_sfr_req_s  sfr_req;
  cbl_mem_req_s  code_req, data_req;
  cbl_sb_req_s   sb_req;
  cbl_sb_rsp_s   sb_rsp;
  int            errors, samples_checked, cyc;
  cbl_boot_window dut (
    .sys_clk(sys_clk), .nrst(nrst), .core_soft_rst(core_soft_rst),
    .boot_strap_pins(straps), .host_req(host_req), .host_rdata(host_rdata),
    .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .core_rst_n(core_rst_n),
    .core_clk_en(core_clk_en), .code_req(code_req), .data_req(data_req),
    .code_to_mem(code_to_mem), .data_to_mem(data_to_mem),
    .code_rdata(code_rdata), .data_rdata(data_rdata),
    .sb_req(sb_req), .sb_rsp(sb_rsp));
  cbl_sb_slave u_sb (
    .sys_clk(sys_clk), .nrst(nrst), .sb_req(sb_req), .sb_rsp(sb_rsp),
    .lat(lat), .rd_count(rd_count), .wr_addr(wr_addr), .wr_data(wr_data));
  // ==========================================================
  // drivers: every task starts and ends 1 ns after a rising edge
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask : step
  task automatic host_wr(input logic [2:0] a, input cbl_word_t d);
    step();
    host_req = '{1'b1, 1'b0, a, d};
    step();
    host_req = '0;
  endtask : host_wr
  task automatic host_rd(input logic [2:0] a, output cbl_word_t d);
    step();
    host_req = '{1'b0, 1'b1, a, 32'h0};
    step();
    host_req = '0;
    d = host_rdata;
  endtask : host_rd
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    step();
    sfr_req = '{1'b1, 1'b0, a, d};
    step();
    sfr_req = '0;
    // a trigger gates the core until the bus answers
    for (int i = 0; i < 100 && core_clk_en !== 1'b1; i++) step();
  endtask : sfr_wr
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    step();
    sfr_req = '{1'b0, 1'b1, a, 8'h00};
    step();
    sfr_req = '0;
    d = sfr_rdata;
  endtask : sfr_rd
  task automatic wait_go();
    cbl_word_t v;
    for (int i = 0; i < 200; i++) begin
      host_rd(`CBL_H_CTRL, v);
      if (v[`CBL_CTRL_GO] === 1'b0) return;
    end
    errors++;
  endtask : wait_go
  task automatic copy(input cbl_word_t s, input cbl_word_t d, input int c);
    host_wr(`CBL_H_SRC, s);
    host_wr(`CBL_H_DEST, d);
    host_wr(`CBL_H_CTRL, 32'(c));
  endtask : copy
  task automatic probe(input logic [15:0] a);
    code_req = '{1'b1, 1'b0, a, 8'h00};
    data_req = '{1'b1, 1'b0, a, 8'h00};
    step();
  endtask : probe
  task automatic soft_pulse();
    repeat (4) step();
    core_soft_rst = 1'b1;
    step();
    core_soft_rst = 1'b0;
    step();
  endtask : soft_pulse
  task automatic results();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  // ==========================================================
  // clock, timeout and main sequence
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end
  initial begin
    {nrst, core_soft_rst, straps, host_req, sfr_req} = '0;
    {code_req, data_req, errors, samples_checked, cyc} = '0;
    lat = 4'h3;
    repeat (4) @(posedge sys_clk);
    #1 nrst = 1'b1;
    repeat (8) step();
    `CHK(core_rst_n, 1'b0)
    host_wr(`CBL_H_CORE, 32'h1);
    repeat (3) step();
    `CHK(core_rst_n, 1'b1)
    foreach (ROWS[i]) begin
      host_wr(`CBL_H_MAP, 32'(ROWS[i].map));
      probe(ROWS[i].a);
      `CHK(code_to_mem, ROWS[i].c)
      `CHK(data_to_mem, ROWS[i].d)
    end
    host_wr(`CBL_H_MAP, 32'h0);
    copy(32'h0, 32'h0010_0008, 1);
    `CHK(core_clk_en, 1'b0)
    host_wr(`CBL_H_CTRL, 32'h1);
    wait_go();
    `CHK(rd_count, 16'd3)
    host_rd(`CBL_H_DEST, rv);
    `CHK(rv, 32'h0010_0008)
    host_wr(`CBL_H_MAP, 32'haf);
    for (int i = 0; i < 3; i++) begin
      probe(16'h0008 + 16'(4 * i));
      `CHK(code_rdata, 8'h10 + 8'(i))
      `CHK(data_rdata, 8'h10 + 8'(i))
    end
    host_wr(`CBL_H_MAP, 32'h0);
    copy(32'h0000_000c, 32'h8008_8008, 1);
    wait_go();
    `CHK(rd_count, 16'd4)
    sfr_wr(`CBL_CORE_MEMORY_MAP, 8'h15);
    probe(16'h0008);
    `CHK(code_rdata, 8'h10)
    `CHK(data_rdata, 8'h13)
    sfr_wr(`CBL_CORE_MEMORY_MAP, 8'h00);
    copy(32'h7000_0000, 32'h0010_0010, 3);
    wait_go();
    `CHK(wr_addr, 32'h7000_0000)
    `CHK(wr_data, 32'h1212_1212)
    lat = 4'h0;
    for (int i = 0; i < 4; i++)
      sfr_wr(`CBL_SFR_DA0 + 8'(i), 8'h11 * 8'(i + 1));
    sfr_wr(`CBL_SFR_AD1, 8'h00);
    sfr_wr(`CBL_SFR_AD1 + 8'h1, 8'h00);
    sfr_wr(`CBL_SFR_AD1 + 8'h2, 8'h70);
    sfr_wr(`CBL_SFR_AD0WR, 8'h08);
    `CHK(wr_addr, 32'h7000_0008)
    `CHK(wr_data, 32'h4433_2211)
    sfr_wr(`CBL_SFR_DA0, 8'h00);
    sfr_wr(`CBL_SFR_AD0RD, 8'h0b);
    `CHK(rd_count, 16'd5)
    for (int i = 0; i < 4; i++) begin
      sfr_rd(`CBL_SFR_DA0 + 8'(i), b);
      `CHK(b, 8'h11 * 8'(i + 1))
    end
    sfr_rd(`CBL_SFR_AD1 + 8'h2, b);
    `CHK(b, 8'h70)
    host_wr(`CBL_H_CORE, 32'h3);
    host_wr(`CBL_H_MAP, 32'haf);
    soft_pulse();
    probe(16'h0000);
    `CHK(code_to_mem, 1'b1)
    host_wr(`CBL_H_CORE, 32'h1);
    soft_pulse();
    probe(16'h0000);
    `CHK(code_to_mem, 1'b0)
    {nrst, straps} = 3'h1;
    step();
    nrst = 1'b1;
    repeat (8) step();
    `CHK(core_rst_n, 1'b1)
    results();
  end
endmodule : tb_cbl_boot_window
